// file: logic/far_exec_regs.vh
// Constants for the far branch / increment execution unit
`ifndef FAR_EXEC_REGS_VH
`define FAR_EXEC_REGS_VH
// Opcode bytes (second byte after escape where binary mode needs it)
`define OP_ESCAPE        8'ha5
`define OP_FAR_CALL_IMM  8'h9a
`define OP_FAR_CALL_IND  8'h99
`define OP_FAR_JUMP_IMM  8'h8a
`define OP_FAR_JUMP_IND  8'h89
`define OP_FAR_RETURN    8'haa
`define OP_INC_SHORT     8'h0b
`define OP_INC_PTR       8'ha3
`define OP_BIT_ONE       8'h20
`define OP_BIT_CLEAR     8'h10
`define OP_ON_CARRY      8'h40
// Operation codes on the decoded op port
`define XOP_NONE         4'h0
`define XOP_FAR_CALL     4'h1
`define XOP_FAR_JUMP     4'h2
`define XOP_FAR_RETURN   4'h3
`define XOP_INC_BYTE     4'h4
`define XOP_INC_SHORT    4'h5
`define XOP_INC_PTR      4'h6
`define XOP_BIT_ONE      4'h7
`define XOP_BIT_CLEAR    4'h8
`define XOP_ON_CARRY     4'h9
// Field positions of the short-immediate second byte
`define SHORT_SIZE_LSB   2
`define SHORT_AMT_LSB    0
// Sizes of the short operand
`define SIZE_BYTE        2'h0
`define SIZE_WORD        2'h1
`define SIZE_DWORD       2'h3
// PC advance for each branch length
`define PC_ADV_CALL      24'h000004
`define PC_ADV_BIT       24'h000003
`define PC_ADV_CARRY     24'h000002
// Stack bytes in a far call or return
`define STACK_BYTES      2'h3
// Reset values
`define PC_RESET         24'hff0000
`define SP_RESET         16'h0007
`endif

// file: logic/far_exec_decode.v
// Opcode decoder with escape-prefix handling
`timescale 1ns/100ps
`default_nettype none
module far_exec_decode (
   input  wire       source_mode_i,
   input  wire [7:0] byte0_i,
   input  wire [7:0] byte1_i,
   output reg  [3:0] xop_o,
   output reg        indirect_o,
   output wire       escaped_o
);
`include "far_exec_regs.vh"
   wire       esc = (byte0_i == `OP_ESCAPE);
   // Extended opcodes need the escape in binary mode only
   wire [7:0] code = (!source_mode_i && esc) ? byte1_i : byte0_i;
   wire       ext_ok = source_mode_i ? !esc : esc;
   assign escaped_o = !source_mode_i && esc;

   always @* begin
      xop_o      = `XOP_NONE;
      indirect_o = 1'b0;
      case (code)
         `OP_FAR_CALL_IMM: if (ext_ok) xop_o = `XOP_FAR_CALL;
         `OP_FAR_CALL_IND: if (ext_ok) begin
            xop_o      = `XOP_FAR_CALL;
            indirect_o = 1'b1;
         end
         `OP_FAR_JUMP_IMM: if (ext_ok) xop_o = `XOP_FAR_JUMP;
         `OP_FAR_JUMP_IND: if (ext_ok) begin
            xop_o      = `XOP_FAR_JUMP;
            indirect_o = 1'b1;
         end
         `OP_FAR_RETURN:   if (ext_ok) xop_o = `XOP_FAR_RETURN;
         `OP_INC_SHORT:    if (ext_ok) xop_o = `XOP_INC_SHORT;
         `OP_INC_PTR:      xop_o = `XOP_INC_PTR;
         `OP_BIT_ONE:      xop_o = `XOP_BIT_ONE;
         `OP_BIT_CLEAR:    xop_o = `XOP_BIT_CLEAR;
         `OP_ON_CARRY:     xop_o = `XOP_ON_CARRY;
         default:          xop_o = `XOP_NONE;
      endcase
   end
endmodule // far_exec_decode
`default_nettype wire

// file: logic/far_exec.v
// Execution unit for far branches, increments and bit branches
`timescale 1ns/100ps
`default_nettype none
module far_exec #(
   parameter PC_W = 24,
   parameter SP_W = 16
) (
   input  wire            sys_clk_i,
   input  wire            rst_b_i,
   input  wire            start_i,
   input  wire            source_mode_i,
   input  wire [7:0]      byte0_i,
   input  wire [7:0]      byte1_i,
   input  wire [7:0]      byte2_i,
   input  wire [7:0]      byte3_i,
   input  wire [7:0]      byte4_i,
   input  wire            inc_byte_i,
   input  wire            operand_is_port_i,
   input  wire [7:0]      byte_operand_i,
   input  wire [7:0]      port_latch_i,
   input  wire [31:0]     reg_operand_i,
   input  wire [31:0]     dword_register_i,
   input  wire [7:0]      stack_rdata_i,
   input  wire            bit_value_i,
   input  wire            bit_is_port_i,
   input  wire            port_latch_bit_i,
   input  wire            carry_flag_i,
   input  wire [15:0]     data_pointer_i,
   output reg             busy_o,
   output reg             done_o,
   output reg  [PC_W-1:0] pc_o,
   output reg  [SP_W-1:0] sp_o,
   output reg             stack_we_o,
   output reg  [SP_W-1:0] stack_addr_o,
   output reg  [7:0]      stack_wdata_o,
   output reg  [31:0]     result_o,
   output reg             result_we_o,
   output reg             flags_we_o,
   output reg             neg_flag_o,
   output reg             zero_flag_o,
   output reg             bit_clear_o,
   output reg  [15:0]     data_pointer_o,
   output reg             data_pointer_we_o,
   output wire            illegal_o
);
`include "far_exec_regs.vh"
   //------------------------------------------------------------
   // Decode
   //------------------------------------------------------------
   wire [3:0] xop;
   wire       indirect;
   wire       escaped;
   far_exec_decode u_decode (
      .source_mode_i (source_mode_i),
      .byte0_i       (byte0_i),
      .byte1_i       (byte1_i),
      .xop_o         (xop),
      .indirect_o    (indirect),
      .escaped_o     (escaped)
   );
   assign illegal_o = start_i && !inc_byte_i && (xop == `XOP_NONE);

   // Operand bytes shift by one when an escape precedes the opcode
   wire [7:0] op1 = escaped ? byte2_i : byte1_i;
   wire [7:0] op2 = escaped ? byte3_i : byte2_i;
   wire [7:0] op3 = escaped ? byte4_i : byte3_i;
   wire [PC_W-1:0] imm_target = {op1, op2, op3};
   wire [PC_W-1:0] far_target = indirect ? dword_register_i[PC_W-1:0]
                                         : imm_target;
   wire [PC_W-1:0] ret_addr   = pc_o + `PC_ADV_CALL;

   //------------------------------------------------------------
   // Sequencer states
   //------------------------------------------------------------
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_PUSH = 4'b0010;
   localparam [3:0] ST_POP  = 4'b0100;
   localparam [3:0] ST_DONE = 4'b1000;

   reg [3:0]      state_r;
   reg [1:0]      cnt_r;
   reg [PC_W-1:0] target_r;
   reg [PC_W-1:0] ret_r;

   // Short increment amount 1, 2 or 4 and operand size
   wire [1:0]  amt_fld = op1[`SHORT_AMT_LSB +: 2];
   wire [1:0]  size    = op1[`SHORT_SIZE_LSB +: 2];
   wire [31:0] amount  = (amt_fld == 2'h0) ? 32'h00000001 :
                         (amt_fld == 2'h1) ? 32'h00000002 : 32'h00000004;
   wire [31:0] short_sum = reg_operand_i + amount;
   reg  [31:0] short_res;
   reg         short_neg;
   always @* begin
      short_res = short_sum;
      short_neg = short_sum[31];
      case (size)
         `SIZE_BYTE: begin
            short_res = {24'h000000, short_sum[7:0]};
            short_neg = short_sum[7];
         end
         `SIZE_WORD: begin
            short_res = {16'h0000, short_sum[15:0]};
            short_neg = short_sum[15];
         end
         default: begin
            short_res = short_sum;
            short_neg = short_sum[31];
         end
      endcase
   end

   // Byte increment source: output latch when operand is a port
   wire [7:0] byte_src = operand_is_port_i ? port_latch_i : byte_operand_i;
   wire [7:0] byte_sum = byte_src + 8'h01;
   wire [15:0] dp_sum  = data_pointer_i + 16'h0001;
   wire        bit_now = bit_is_port_i ? port_latch_bit_i : bit_value_i;
   wire [PC_W-1:0] rel_bit = {{(PC_W-8){op2[7]}}, op2};
   wire [PC_W-1:0] rel_cy  = {{(PC_W-8){op1[7]}}, op1};

   //------------------------------------------------------------
   // Execution
   //------------------------------------------------------------
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r           <= ST_IDLE;
         cnt_r             <= 2'h0;
         target_r          <= {PC_W{1'b0}};
         ret_r             <= {PC_W{1'b0}};
         busy_o            <= 1'b0;
         done_o            <= 1'b0;
         pc_o              <= `PC_RESET;
         sp_o              <= `SP_RESET;
         stack_we_o        <= 1'b0;
         stack_addr_o      <= {SP_W{1'b0}};
         stack_wdata_o     <= 8'h00;
         result_o          <= 32'h00000000;
         result_we_o       <= 1'b0;
         flags_we_o        <= 1'b0;
         neg_flag_o        <= 1'b0;
         zero_flag_o       <= 1'b0;
         bit_clear_o       <= 1'b0;
         data_pointer_o    <= 16'h0000;
         data_pointer_we_o <= 1'b0;
      end else begin
         done_o            <= 1'b0;
         stack_we_o        <= 1'b0;
         result_we_o       <= 1'b0;
         flags_we_o        <= 1'b0;
         bit_clear_o       <= 1'b0;
         data_pointer_we_o <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start_i && inc_byte_i) begin
                  result_o    <= {24'h000000, byte_sum};
                  result_we_o <= 1'b1;
                  flags_we_o  <= 1'b1;
                  neg_flag_o  <= byte_sum[7];
                  zero_flag_o <= (byte_sum == 8'h00);
                  done_o      <= 1'b1;
               end else if (start_i) begin
                  case (xop)
                     `XOP_FAR_CALL: begin
                        target_r     <= far_target;
                        ret_r        <= ret_addr;
                        busy_o       <= 1'b1;
                        cnt_r        <= 2'h0;
                        state_r      <= ST_PUSH;
                     end
                     `XOP_FAR_JUMP: begin
                        pc_o   <= far_target;
                        done_o <= 1'b1;
                     end
                     `XOP_FAR_RETURN: begin
                        stack_addr_o <= sp_o;
                        busy_o       <= 1'b1;
                        cnt_r        <= 2'h0;
                        state_r      <= ST_POP;
                     end
                     `XOP_INC_SHORT: begin
                        result_o    <= short_res;
                        result_we_o <= 1'b1;
                        flags_we_o  <= 1'b1;
                        neg_flag_o  <= short_neg;
                        zero_flag_o <= (short_res == 32'h00000000);
                        done_o      <= 1'b1;
                     end
                     `XOP_INC_PTR: begin
                        data_pointer_o    <= dp_sum;
                        data_pointer_we_o <= 1'b1;
                        flags_we_o        <= 1'b1;
                        neg_flag_o        <= dp_sum[15];
                        zero_flag_o       <= (dp_sum == 16'h0000);
                        done_o            <= 1'b1;
                     end
                     `XOP_BIT_ONE: begin
                        pc_o   <= pc_o + `PC_ADV_BIT
                                  + (bit_value_i ? rel_bit : {PC_W{1'b0}});
                        done_o <= 1'b1;
                     end
                     `XOP_BIT_CLEAR: begin
                        pc_o        <= pc_o + `PC_ADV_BIT
                                       + (bit_now ? rel_bit : {PC_W{1'b0}});
                        bit_clear_o <= bit_now;
                        done_o      <= 1'b1;
                     end
                     `XOP_ON_CARRY: begin
                        pc_o   <= pc_o + `PC_ADV_CARRY
                                  + (carry_flag_i ? rel_cy : {PC_W{1'b0}});
                        done_o <= 1'b1;
                     end
                     default: done_o <= 1'b0;
                  endcase
               end
            end
            ST_PUSH: begin
               // High byte first, SP pre-incremented per byte
               stack_we_o    <= 1'b1;
               stack_addr_o  <= sp_o + 16'h0001;
               sp_o          <= sp_o + 16'h0001;
               stack_wdata_o <= (cnt_r == 2'h0) ? ret_r[23:16] :
                                (cnt_r == 2'h1) ? ret_r[15:8] : ret_r[7:0];
               cnt_r         <= cnt_r + 2'h1;
               if (cnt_r == `STACK_BYTES - 2'h1) begin
                  pc_o    <= target_r;
                  state_r <= ST_DONE;
               end
            end
            ST_POP: begin
               // Read data for the address set last cycle: low byte first
               case (cnt_r)
                  2'h0:    pc_o[7:0]   <= stack_rdata_i;
                  2'h1:    pc_o[15:8]  <= stack_rdata_i;
                  default: pc_o[23:16] <= stack_rdata_i;
               endcase
               sp_o         <= sp_o - 16'h0001;
               stack_addr_o <= sp_o - 16'h0001;
               cnt_r        <= cnt_r + 2'h1;
               if (cnt_r == `STACK_BYTES - 2'h1)
                  state_r <= ST_DONE;
            end
            ST_DONE: begin
               busy_o  <= 1'b0;
               done_o  <= 1'b1;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule // far_exec
`default_nettype wire

// file: verification/far_exec_monitor.sv
// Port assertions for the far execution unit
`timescale 1ns/100ps
`default_nettype none
module far_exec_monitor #(
   parameter SP_W = 16
) (
   input wire logic            sys_clk_i,
   input wire logic            rst_b_i,
   input wire logic            busy_o,
   input wire logic            done_o,
   input wire logic [SP_W-1:0] sp_o,
   input wire logic            stack_we_o,
   input wire logic [SP_W-1:0] stack_addr_o,
   input wire logic            flags_we_o,
   input wire logic            result_we_o,
   input wire logic            illegal_o
);
   logic [2:0]      push_cnt_r;
   logic            seen_r;
   logic [SP_W-1:0] sp_idle_r;
   // ----
   // Pushes counted and busy seen since the last completion, SP sampled while idle and held while busy
   // ----
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         push_cnt_r <= 3'h0;
         seen_r     <= 1'b0;
         sp_idle_r  <= '0;
      end else begin
         push_cnt_r <= done_o ? 3'h0 : push_cnt_r + {2'h0, stack_we_o};
         seen_r     <= done_o ? 1'b0 : (seen_r | busy_o);
         sp_idle_r  <= busy_o ? sp_idle_r : sp_o;
      end
   end
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   chk_far_flags: assert property (busy_o |-> !flags_we_o && !result_we_o)
      else $error("flags or result written in far op");
   chk_push_run: assert property ($rose(stack_we_o) |-> stack_we_o[*3] ##1 !stack_we_o)
      else $error("push burst is not three bytes");
   chk_push_step: assert property (stack_we_o && $past(stack_we_o) |->
      stack_addr_o == $past(stack_addr_o) + 1'b1) else $error("push address not rising");
   chk_push_busy: assert property (stack_we_o |-> busy_o)
      else $error("push outside busy");
   chk_call_done: assert property ($fell(stack_we_o) |-> ##[0:1] done_o)
      else $error("no completion after pushes");
   chk_sp_call: assert property (done_o && push_cnt_r == 3'h3 |-> sp_o == sp_idle_r + 2'h3)
      else $error("stack pointer not up by three");
   chk_sp_ret: assert property (done_o && seen_r && push_cnt_r == 3'h0 |->
      sp_o == sp_idle_r - 2'h3) else $error("stack pointer not down by three");
   chk_illegal_quiet: assert property (illegal_o && !busy_o |=> !done_o && !result_we_o)
      else $error("refused op completed");
   cover property (done_o && push_cnt_r == 3'h3);
   cover property (done_o && seen_r && push_cnt_r == 3'h0);
   cover property (illegal_o);
endmodule // far_exec_monitor
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the far execution unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic [23:0] pc;
      logic [15:0] sp;
      logic [31:0] r;
      logic [31:0] m;
      logic [1:0]  nz;
      logic [1:0]  k;
      logic        c;
   } exp_t;
   logic        sys_clk_i, rst_b_i, start_i, source_mode_i, inc_byte_i, operand_is_port_i;
   logic        bit_value_i, bit_is_port_i, port_latch_bit_i, carry_flag_i, clr_seen;
   logic [7:0]  byte0_i, byte1_i, byte2_i, byte3_i, byte4_i, byte_operand_i, port_latch_i, f;
   logic [31:0] reg_operand_i, dword_register_i, result_o, v, m;
   logic [15:0] data_pointer_i, data_pointer_o, sp_o, stack_addr_o, sp_m, lfsr;
   logic [23:0] pc_o, pc_m, t;
   logic [7:0]  stack_wdata_o, mem [0:255];
   logic        busy_o, done_o, stack_we_o, result_we_o, flags_we_o, neg_flag_o, zero_flag_o;
   logic        bit_clear_o, data_pointer_we_o, illegal_o, tk;
   logic [3:0]  w;
   logic [41:0] b;
   int          error_cnt = 0, checks = 0, n;
   exp_t        q [$];
   exp_t        e;
   wire  [7:0]  stack_rdata_i = mem[stack_addr_o[7:0]];

   far_exec dut (
      .sys_clk_i         (sys_clk_i),
      .rst_b_i           (rst_b_i),
      .start_i           (start_i),
      .source_mode_i     (source_mode_i),
      .byte0_i           (byte0_i),
      .byte1_i           (byte1_i),
      .byte2_i           (byte2_i),
      .byte3_i           (byte3_i),
      .byte4_i           (byte4_i),
      .inc_byte_i        (inc_byte_i),
      .operand_is_port_i (operand_is_port_i),
      .byte_operand_i    (byte_operand_i),
      .port_latch_i      (port_latch_i),
      .reg_operand_i     (reg_operand_i),
      .dword_register_i  (dword_register_i),
      .stack_rdata_i     (stack_rdata_i),
      .bit_value_i       (bit_value_i),
      .bit_is_port_i     (bit_is_port_i),
      .port_latch_bit_i  (port_latch_bit_i),
      .carry_flag_i      (carry_flag_i),
      .data_pointer_i    (data_pointer_i),
      .busy_o            (busy_o),
      .done_o            (done_o),
      .pc_o              (pc_o),
      .sp_o              (sp_o),
      .stack_we_o        (stack_we_o),
      .stack_addr_o      (stack_addr_o),
      .stack_wdata_o     (stack_wdata_o),
      .result_o          (result_o),
      .result_we_o       (result_we_o),
      .flags_we_o        (flags_we_o),
      .neg_flag_o        (neg_flag_o),
      .zero_flag_o       (zero_flag_o),
      .bit_clear_o       (bit_clear_o),
      .data_pointer_o    (data_pointer_o),
      .data_pointer_we_o (data_pointer_we_o),
      .illegal_o         (illegal_o)
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic cmp_pc(input logic [23:0] g, input logic [23:0] x);
      cmp({8'h0, g}, {8'h0, x});
   endtask
   task automatic cmp_sp(input logic [15:0] g, input logic [15:0] x);
      cmp({16'h0, g}, {16'h0, x});
   endtask
   task automatic cmp_res(input logic [31:0] g, input logic [31:0] x);
      cmp(g, x);
   endtask
   task automatic cmp_bits(input logic [3:0] g, input logic [3:0] x);
      cmp({28'h0, g}, {28'h0, x});
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic go(input logic [41:0] bb, input logic [23:0] pc, input logic [15:0] sp,
         input logic [1:0] k, input logic [31:0] r, input logic [31:0] mk,
         input logic [1:0] nz, input logic c);
      {source_mode_i, inc_byte_i, byte0_i, byte1_i, byte2_i, byte3_i, byte4_i} = bb;
      start_i = 1'b1;
      q.push_back('{pc, sp, r, mk, nz, k, c});
      pc_m = pc;
      sp_m = sp;
      @(negedge sys_clk_i);
   endtask
   task automatic fin();
      start_i = 1'b0;
      for (n = 0; n < 20 && done_o !== 1'b1; n++)
         @(negedge sys_clk_i);
      if (done_o !== 1'b1) begin
         cmp_bits({3'h0, done_o}, 4'h1);
         end_sim();
      end else begin
         @(negedge sys_clk_i);
      end
   endtask
   task automatic far(input logic [41:0] bb, input logic [23:0] pc, input logic [15:0] sp);
      go(bb, pc, sp, 2'h0, 32'h0, 32'h0, 2'h0, 1'b0);
      fin();
   endtask
   // ----
   // Completion watcher
   // ----
   always @(negedge sys_clk_i) begin
      clr_seen = clr_seen | bit_clear_o;
      if (stack_we_o === 1'b1)
         mem[stack_addr_o[7:0]] = stack_wdata_o;
      if (done_o === 1'b1) begin
         if (q.size() == 0) begin
            cmp(32'h1, 32'h0);
         end else begin
            e = q.pop_front();
            cmp_sp(sp_o, e.sp);
            if (e.k == 2'h0) cmp_pc(pc_o, e.pc);
            if (e.k == 2'h1) cmp_res(result_o & e.m, e.r);
            if (e.k != 2'h0) cmp_bits({2'h0, neg_flag_o, zero_flag_o}, {2'h0, e.nz});
            if (e.k == 2'h2) cmp_res({16'h0, data_pointer_o}, e.r);
            w = {1'b0, e.k == 2'h1, e.k != 2'h0, e.k == 2'h2};
            cmp_bits({1'b0, result_we_o, flags_we_o, data_pointer_we_o}, w);
            cmp_bits({3'h0, clr_seen}, {3'h0, e.c});
         end
         clr_seen = 1'b0;
      end
   end
   // ----
   // Main sequence
   // ----
   initial begin
      {start_i, inc_byte_i, operand_is_port_i, bit_value_i, bit_is_port_i} = 5'h0;
      {port_latch_bit_i, carry_flag_i, rst_b_i, clr_seen, source_mode_i} = 5'h1;
      {byte0_i, byte1_i, byte2_i, byte3_i, byte4_i, byte_operand_i, port_latch_i} = 56'h0;
      {reg_operand_i, dword_register_i, data_pointer_i} = 80'h0;
      lfsr = 16'hcfd0;
      repeat (4) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      cmp({8'h0, pc_o}, 32'hff0000);
      cmp({16'h0, sp_o}, 32'h7);
      far({2'h2, 40'h8a12345600}, 24'h123456, 16'h7);
      far({2'h0, 40'ha58aabcdef}, 24'habcdef, 16'h7);
      {source_mode_i, byte0_i} = 9'h08a;
      start_i = 1'b1;
      #2;
      cmp_bits({3'h0, illegal_o}, 4'h1);
      @(negedge sys_clk_i);
      // Second start while busy must be ignored
      go({2'h2, 40'h9a12345600}, 24'h123456, 16'ha, 2'h0, 32'h0, 32'h0, 2'h0, 1'b0);
      byte0_i = 8'h8a;
      @(negedge sys_clk_i);
      fin();
      far({2'h2, 40'haa00000000}, 24'habcdf3, 16'h7);
      t = {rnd(), rnd(), rnd()};
      dword_register_i = {8'h5a, t};
      far({2'h2, 40'h9900000000}, t, 16'ha);
      t = {rnd(), rnd(), rnd()};
      dword_register_i = {8'ha5, t};
      far({2'h2, 40'h8900000000}, t, 16'ha);
      far({2'h2, 40'haa00000000}, 24'habcdf7, 16'h7);
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 32'hff : (i == 1) ? 32'h7f : {24'h0, rnd()};
         operand_is_port_i = i[0];
         port_latch_i = v[7:0];
         byte_operand_i = i[0] ? ~v[7:0] : v[7:0];
         v = (v + 32'h1) & 32'hff;
         go({2'h3, 40'h0}, pc_m, sp_m, 2'h1, v, 32'hff, {v[7], v == 32'h0}, 1'b0);
      end
      for (int i = 0; i < 9; i++) begin
         m = (i < 3) ? 32'hff : (i < 6) ? 32'hffff : 32'hffffffff;
         reg_operand_i = (i % 3 == 0) ? 32'hffffffff : {rnd(), rnd(), rnd(), rnd()};
         v = (reg_operand_i + (32'h1 << (i % 3))) & m;
         f = {4'h0, (i < 3) ? 2'h0 : (i < 6) ? 2'h1 : 2'h3, 2'(i % 3)};
         b = i[0] ? {2'h0, 8'ha5, 8'h0b, f, 16'h0} : {2'h2, 8'h0b, f, 24'h0};
         go(b, pc_m, sp_m, 2'h1, v, m, {|(v & ~(m >> 1)), v == 32'h0}, 1'b0);
      end
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 32'h12fe : (i == 1) ? 32'h12ff : 32'hffff;
         data_pointer_i = v[15:0];
         v = (v + 32'h1) & 32'hffff;
         go({2'h2, 40'ha300000000}, pc_m, sp_m, 2'h2, v, 0, {v[15], v == 32'h0}, 0);
      end
      for (int i = 0; i < 8; i++) begin
         f = rnd();
         {bit_is_port_i, bit_value_i, port_latch_bit_i, carry_flag_i} = {i[2], i[0], ~i[0], i[0]};
         tk = (i[2] && !i[1]) ? ~i[0] : i[0];
         t = tk ? {{16{f[7]}}, f} : 24'h0;
         b = (i < 2) ? {2'h2, 8'h20, 8'h3c, f, 16'h0} : {2'h2, 8'h10, 8'h3c, f, 16'h0};
         if (i > 5) b = {2'h2, 8'h40, f, 24'h0};
         t = t + ((i > 5) ? 24'h2 : 24'h3);
         go(b, pc_m + t, sp_m, 2'h0, 0, 0, 0, i > 1 && i < 6 && tk);
      end
      fin();
      cmp_res(q.size(), 32'h0);
      end_sim();
   end
endmodule // testbench
bind far_exec far_exec_monitor #(.SP_W(SP_W)) mon (
   .sys_clk_i    (sys_clk_i),
   .rst_b_i      (rst_b_i),
   .busy_o       (busy_o),
   .done_o       (done_o),
   .sp_o         (sp_o),
   .stack_we_o   (stack_we_o),
   .stack_addr_o (stack_addr_o),
   .flags_we_o   (flags_we_o),
   .result_we_o  (result_we_o),
   .illegal_o    (illegal_o)
);
`default_nettype wire
